// file: cmx_pkg.sv
/*
 * Shared constants for the complex mixer and IQ correction datapath:
 * configuration addresses, field positions, reset values, arithmetic
 * scaling and the rotation table of the sine/cosine generator.
 * Assumes one clock domain and a byte-wide configuration write port.
 */
package cmx_pkg;

    // ------------------------------------------------------------
    // Configuration addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CMX_ADDR_CFG2 = 8'h02;
    localparam logic [7:0] CMX_ADDR_FREQ0 = 8'h09;
    localparam logic [7:0] CMX_ADDR_FREQ1 = 8'h0A;
    localparam logic [7:0] CMX_ADDR_FREQ2 = 8'h0B;
    localparam logic [7:0] CMX_ADDR_FREQ3 = 8'h0C;
    localparam logic [7:0] CMX_ADDR_PHASE_HI = 8'h0D;
    localparam logic [7:0] CMX_ADDR_PHASE_LO = 8'h0E;

    // ------------------------------------------------------------
    // Fields of the third configuration register
    // ------------------------------------------------------------
    localparam int CMX_GAIN_BIT = 6;
    localparam int CMX_CM_LSB = 0;
    localparam int CMX_CM_W = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CMX_FREQ_RST = 32'h0000_0000;
    localparam logic [15:0] CMX_PHASE_RST = 16'h0000;
    localparam logic [7:0] CMX_CFG2_RST = 8'h00;

    // ------------------------------------------------------------
    // Interpolation modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMX_TWO_TIMES_MODE = 2'b00,
        CMX_LOW_RATE_FOUR_TIMES_MODE = 2'b01,
        CMX_FULL_RATE_FOUR_TIMES_MODE = 2'b10,
        CMX_EIGHT_TIMES_MODE = 2'b11
    } cmx_rate_t;

    // ------------------------------------------------------------
    // Arithmetic scaling
    // ------------------------------------------------------------
    localparam int CMX_SHIFT_LOW_GAIN = 16;
    localparam int CMX_SHIFT_HIGH_GAIN = 15;
    localparam int CMX_QMC_SHIFT = 10;
    localparam int CMX_CORDIC_STAGES = 15;
    localparam logic signed [17:0] CMX_CORDIC_K = 18'sh04DB9;
    localparam logic [15:0] CMX_HALF_TURN = 16'h8000;
    localparam logic [16:0] CMX_ATAN [0:14] = '{
        17'h02000, 17'h012E4, 17'h009FB, 17'h00511, 17'h0028B,
        17'h00146, 17'h000A3, 17'h00051, 17'h00029, 17'h00014,
        17'h0000A, 17'h00005, 17'h00003, 17'h00001, 17'h00001
    };

endpackage : cmx_pkg

// file: cmx_sincos.sv
/*
 * Combinational sine/cosine generator: rotation-based, 16-bit phase in,
 * signed 16-bit cosine and sine out at near full scale.
 * Assumes the caller registers the result; the path is long.
 */
`timescale 1ns/1ps

module cmx_sincos
    import cmx_pkg::*;
(
    input wire logic [15:0] angle,
    output logic signed [15:0] cos_o,
    output logic signed [15:0] sin_o
);

    // ------------------------------------------------------------
    // Quadrant fold
    // ------------------------------------------------------------
    logic flip;
    logic [15:0] folded;
    logic signed [17:0] xs [0:CMX_CORDIC_STAGES];
    logic signed [17:0] ys [0:CMX_CORDIC_STAGES];
    logic signed [16:0] zs [0:CMX_CORDIC_STAGES];
    logic signed [17:0] xf;
    logic signed [17:0] yf;

    // Rotation converges only within a quarter turn either side of zero
    assign flip = angle[15] ^ angle[14];
    assign folded = flip ? (angle ^ CMX_HALF_TURN) : angle;
    assign xs[0] = CMX_CORDIC_K;
    assign ys[0] = 18'sh00000;
    assign zs[0] = {folded[15], folded};

    // ------------------------------------------------------------
    // Rotation stages
    // ------------------------------------------------------------
    genvar i;
    for (i = 0; i < CMX_CORDIC_STAGES; i++) begin : g_stage
        assign xs[i+1] = zs[i][16] ? xs[i] + (ys[i] >>> i) : xs[i] - (ys[i] >>> i);
        assign ys[i+1] = zs[i][16] ? ys[i] - (xs[i] >>> i) : ys[i] + (xs[i] >>> i);
        assign zs[i+1] = zs[i][16] ? zs[i] + signed'(CMX_ATAN[i]) : zs[i] - signed'(CMX_ATAN[i]);
    end

    // Undo the fold, then clip the small overshoot of the gain constant
    assign xf = flip ? -xs[CMX_CORDIC_STAGES] : xs[CMX_CORDIC_STAGES];
    assign yf = flip ? -ys[CMX_CORDIC_STAGES] : ys[CMX_CORDIC_STAGES];
    assign cos_o = (xf > 18'sh07FFF) ? 16'sh7FFF : (xf < -18'sh07FFF) ? -16'sh7FFF : xf[15:0];
    assign sin_o = (yf > 18'sh07FFF) ? 16'sh7FFF : (yf < -18'sh07FFF) ? -16'sh7FFF : yf[15:0];

endmodule : cmx_sincos

// file: cmx_mixer.sv
/*
 * Complex mixing datapath: phase-accumulating oscillator with fine
 * mixer, IQ gain/phase correction, then fixed coarse mixer.
 * Assumes SAMPLE_EN pulses once per output-rate sample from logic on
 * CLK_SYS; the filters around this block live elsewhere.
 */
`timescale 1ns/1ps

module cmx_mixer
    import cmx_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic SAMPLE_EN,
    input wire logic [1:0] RATE_MODE,
    input wire logic PHASE_SYNC_STROBE,
    input wire logic CFG_WE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA,
    input wire logic [10:0] QMC_GAIN_I,
    input wire logic [10:0] QMC_GAIN_Q,
    input wire logic [9:0] QMC_SKEW,
    input wire logic signed [15:0] A_IN,
    input wire logic signed [15:0] B_IN,
    output logic signed [15:0] A_OUT,
    output logic signed [15:0] B_OUT,
    output logic OUT_VALID
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] freq;
        logic [15:0] phase;
        logic [7:0] cfg2;
        logic [31:0] acc;
        logic div;
        logic [1:0] cnt;
        logic [2:0] sync_ff;
        logic signed [15:0] fm_i;
        logic signed [15:0] fm_q;
        logic signed [15:0] qm_i;
        logic signed [15:0] qm_q;
        logic signed [15:0] out_a;
        logic signed [15:0] out_b;
        logic out_vld;
    } cmx_state_t;

    localparam cmx_state_t CMX_STATE_RST = '{
        freq: CMX_FREQ_RST,
        phase: CMX_PHASE_RST,
        cfg2: CMX_CFG2_RST,
        acc: 32'h0000_0000,
        div: 1'b0,
        cnt: 2'h0,
        sync_ff: 3'h0,
        fm_i: 16'sh0000,
        fm_q: 16'sh0000,
        qm_i: 16'sh0000,
        qm_q: 16'sh0000,
        out_a: 16'sh0000,
        out_b: 16'sh0000,
        out_vld: 1'b0
    };

    cmx_state_t st_q;
    cmx_state_t st_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clamp to 16 bits; negation of full-scale negative also lands here
    function automatic logic signed [15:0] cmx_sat16(input logic signed [33:0] v);
        logic signed [15:0] r;
        r = v[15:0];
        if (v > 34'sh0_0000_7FFF) begin
            r = 16'sh7FFF;
        end else if (v < -34'sh0_0000_8000) begin
            r = 16'sh8000;
        end
        return r;
    endfunction : cmx_sat16

    function automatic logic signed [15:0] cmx_neg(input logic signed [15:0] v, input logic n);
        return n ? cmx_sat16(-34'(v)) : v;
    endfunction : cmx_neg

    // ------------------------------------------------------------
    // Combinational terms
    // ------------------------------------------------------------
    logic half_rate;
    logic sync_edge;
    logic nco_tick;
    logic gain_high;
    logic [3:0] cm_sel;
    logic [15:0] sc_angle;
    logic signed [15:0] nco_cos;
    logic signed [15:0] nco_sin;
    logic signed [33:0] mix_i;
    logic signed [33:0] mix_q;
    logic signed [33:0] qmc_i;
    logic signed [33:0] qmc_q;

    // The second and third sync flops feed the edge detector
    assign sync_edge = st_q.sync_ff[1] & ~st_q.sync_ff[2];
    assign half_rate = (cmx_rate_t'(RATE_MODE) != CMX_FULL_RATE_FOUR_TIMES_MODE);
    assign nco_tick = SAMPLE_EN & (~half_rate | ~st_q.div);
    assign gain_high = st_q.cfg2[CMX_GAIN_BIT];
    assign cm_sel = st_q.cfg2[CMX_CM_LSB +: CMX_CM_W];
    assign sc_angle = st_q.acc[31:16] + st_q.phase;

    cmx_sincos u_sincos (
        .angle(sc_angle),
        .cos_o(nco_cos),
        .sin_o(nco_sin)
    );

    // Complex rotation; A is I and B is Q
    assign mix_i = 34'(A_IN * nco_cos) - 34'(B_IN * nco_sin);
    assign mix_q = 34'(A_IN * nco_sin) + 34'(B_IN * nco_cos);

    // Gain and skew use 10 fraction bits; skew leaks I into Q
    assign qmc_i = 34'(st_q.fm_i * $signed({1'b0, QMC_GAIN_I}));
    assign qmc_q = 34'(st_q.fm_q * $signed({1'b0, QMC_GAIN_Q}))
                 + 34'(st_q.fm_i * $signed(QMC_SKEW));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic na;
        logic nb;
        logic sw;
        st_d = st_q;
        na = 1'b0;
        nb = 1'b0;
        sw = 1'b0;
        st_d.sync_ff = {st_q.sync_ff[1:0], PHASE_SYNC_STROBE};
        st_d.out_vld = SAMPLE_EN;

        // Byte writes into the configuration words
        if (CFG_WE) begin
            unique case (CFG_ADDR)
                CMX_ADDR_FREQ0: st_d.freq[7:0] = CFG_WDATA;
                CMX_ADDR_FREQ1: st_d.freq[15:8] = CFG_WDATA;
                CMX_ADDR_FREQ2: st_d.freq[23:16] = CFG_WDATA;
                CMX_ADDR_FREQ3: st_d.freq[31:24] = CFG_WDATA;
                CMX_ADDR_PHASE_HI: st_d.phase[15:8] = CFG_WDATA;
                CMX_ADDR_PHASE_LO: st_d.phase[7:0] = CFG_WDATA;
                CMX_ADDR_CFG2: st_d.cfg2 = CFG_WDATA;
                default: ;
            endcase
        end

        // Oscillator: plain modulo add covers negative tuning words too
        if (sync_edge) begin
            st_d.acc = 32'h0000_0000;
            st_d.div = 1'b0;
        end else if (SAMPLE_EN) begin
            st_d.div = half_rate ? ~st_q.div : 1'b0;
            if (nco_tick) begin
                st_d.acc = st_q.acc + st_q.freq;
            end
        end

        // Fine mixer holds its value between half-rate ticks
        if (nco_tick) begin
            st_d.fm_i = cmx_sat16(mix_i >>> (gain_high ? CMX_SHIFT_HIGH_GAIN
                                                       : CMX_SHIFT_LOW_GAIN));
            st_d.fm_q = cmx_sat16(mix_q >>> (gain_high ? CMX_SHIFT_HIGH_GAIN
                                                       : CMX_SHIFT_LOW_GAIN));
        end

        // IQ correction at the output rate, before the coarse mixer
        if (SAMPLE_EN) begin
            st_d.qm_i = cmx_sat16(qmc_i >>> CMX_QMC_SHIFT);
            st_d.qm_q = cmx_sat16(qmc_q >>> CMX_QMC_SHIFT);
        end

        // Coarse mixer sign and swap selection per sequence position
        unique case (cm_sel[3:2])
            2'b00: begin
                na = 1'b0;
                nb = 1'b0;
                sw = 1'b0;
            end
            2'b01: begin
                na = st_q.cnt[0] ^ ~cm_sel[1];
                nb = st_q.cnt[0] ^ ~cm_sel[0];
                sw = 1'b0;
            end
            2'b10: begin
                na = (st_q.cnt[1] ^ st_q.cnt[0]) ^ cm_sel[1];
                nb = st_q.cnt[1] ^ cm_sel[0];
                sw = st_q.cnt[0];
            end
            2'b11: begin
                na = st_q.cnt[1] ^ cm_sel[1];
                nb = (st_q.cnt[1] ^ st_q.cnt[0]) ^ cm_sel[0];
                sw = st_q.cnt[0];
            end
        endcase

        // Both channels stay live so either can feed a real output
        if (SAMPLE_EN) begin
            if (sw) begin
                st_d.out_a = cmx_neg(st_q.qm_q, na);
                st_d.out_b = cmx_neg(st_q.qm_i, nb);
            end else begin
                st_d.out_a = cmx_neg(st_q.qm_i, na);
                st_d.out_b = cmx_neg(st_q.qm_q, nb);
            end
        end

        // Sequence position; sync realigns it with the oscillator
        if (sync_edge) begin
            st_d.cnt = 2'h0;
        end else if (SAMPLE_EN) begin
            st_d.cnt = st_q.cnt + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= CMX_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign A_OUT = st_q.out_a;
    assign B_OUT = st_q.out_b;
    assign OUT_VALID = st_q.out_vld;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    sequence sync_seen;
        $rose(PHASE_SYNC_STROBE) ##2 1'b1;
    endsequence

    sequence half_pair;
        (nco_tick && half_rate && !sync_edge) ##1 (SAMPLE_EN && half_rate && !sync_edge);
    endsequence

    acc_clear_a: assert property (sync_edge |=> st_q.acc == 32'h0000_0000)
        else $error("accumulator not cleared by sync");

    sync_path_a: assert property (sync_seen |-> sync_edge || !st_q.sync_ff[1])
        else $error("sync edge missing after strobe rise");

    acc_step_a: assert property ((nco_tick && !sync_edge)
        |=> st_q.acc == $past(st_q.acc) + $past(st_q.freq))
        else $error("accumulator step wrong");

    acc_hold_a: assert property ((!nco_tick && !sync_edge) |=> $stable(st_q.acc))
        else $error("accumulator moved without a tick");

    half_skip_a: assert property (half_pair |-> !nco_tick)
        else $error("half-rate oscillator ticked twice");

    full_tick_a: assert property ((SAMPLE_EN && !half_rate) |-> nco_tick)
        else $error("full-rate oscillator missed a sample");

    freq_load_a: assert property ((CFG_WE && CFG_ADDR == CMX_ADDR_FREQ3)
        |=> st_q.freq[31:24] == $past(CFG_WDATA))
        else $error("tuning word top byte not loaded");

    phase_load_a: assert property ((CFG_WE && CFG_ADDR == CMX_ADDR_PHASE_HI)
        |=> st_q.phase[15:8] == $past(CFG_WDATA))
        else $error("phase offset high byte not loaded");

    pass_mix_a: assert property ((SAMPLE_EN && cm_sel[3:2] == 2'b00)
        |=> A_OUT == $past(st_q.qm_i) && B_OUT == $past(st_q.qm_q))
        else $error("bypass coarse mix altered data");

    unity_gain_a: assert property ((SAMPLE_EN && QMC_GAIN_I == 11'h400)
        |=> st_q.qm_i == $past(st_q.fm_i))
        else $error("unity correction gain altered I");

    out_valid_a: assert property (SAMPLE_EN |=> OUT_VALID ##1 (OUT_VALID == $past(SAMPLE_EN)))
        else $error("output valid misaligned");

    // Coarse sequence spot checks: source channel and sign at one position
    property plain_step(logic [3:0] code, logic [1:0] pos, logic neg_a, logic neg_b);
        (SAMPLE_EN && cm_sel == code && st_q.cnt == pos)
            |=> A_OUT == cmx_neg($past(st_q.qm_i), neg_a)
                && B_OUT == cmx_neg($past(st_q.qm_q), neg_b);
    endproperty

    // Swapped positions feed A from Q and B from I
    property swap_step(logic [3:0] code, logic [1:0] pos, logic neg_a, logic neg_b);
        (SAMPLE_EN && cm_sel == code && st_q.cnt == pos)
            |=> A_OUT == cmx_neg($past(st_q.qm_q), neg_a)
                && B_OUT == cmx_neg($past(st_q.qm_i), neg_b);
    endproperty

    half_start_a: assert property (plain_step(4'b0100, 2'h0, 1'b1, 1'b1))
        else $error("half-rate mix start sign wrong");

    half_flip_a: assert property (plain_step(4'b0110, 2'h1, 1'b1, 1'b0))
        else $error("half-rate mix second sign wrong");

    plus_swap_a: assert property (swap_step(4'b1000, 2'h1, 1'b1, 1'b0))
        else $error("plus quarter mix step one wrong");

    plus_mid_a: assert property (plain_step(4'b1001, 2'h2, 1'b1, 1'b0))
        else $error("plus quarter mix step two wrong");

    plus_end_a: assert property (swap_step(4'b1011, 2'h3, 1'b1, 1'b0))
        else $error("plus quarter mix step three wrong");

    minus_swap_a: assert property (swap_step(4'b1100, 2'h1, 1'b0, 1'b1))
        else $error("minus quarter mix step one wrong");

    minus_mid_a: assert property (plain_step(4'b1110, 2'h2, 1'b0, 1'b1))
        else $error("minus quarter mix step two wrong");

    minus_end_a: assert property (swap_step(4'b1111, 2'h3, 1'b0, 1'b1))
        else $error("minus quarter mix step three wrong");

endmodule : cmx_mixer

// file: cmx_src_model.sv
/*
 * Upstream sample source standing in for the interpolation filters.
 * Assumes the bench clock; every change lands on the falling edge.
 */
`timescale 1ns/1ps

module cmx_src_model (
    input wire logic clk,
    input wire logic run,
    input wire logic slow,
    input wire logic signed [15:0] a_val,
    input wire logic signed [15:0] b_val,
    output logic sample_en,
    output logic signed [15:0] a_out,
    output logic signed [15:0] b_out
);
    logic gap_q = 1'b0;

    // ------------------------------------------------------------
    // Sample stepping
    // ------------------------------------------------------------
    initial begin
        sample_en = 1'b0;
        a_out = 16'h0000;
        b_out = 16'h0000;
    end

    // One step per clock at 125 MHz (every other clock when slow), well under the rate ceilings
    // Idle cycles show inverted data so stale values cannot pass
    always @(negedge clk) begin
        gap_q <= slow ? ~gap_q : 1'b0;
        if (run && !gap_q) begin
            sample_en <= 1'b1;
            a_out <= a_val;
            b_out <= b_val;
        end else begin
            sample_en <= 1'b0;
            a_out <= ~a_val;
            b_out <= ~b_val;
        end
    end
endmodule : cmx_src_model

// file: tb_cmx_mixer.sv
/*
 * Self-checking bench for cmx_mixer: reset, config port, fine mixer,
 * sync, IQ correction and every coarse mixer code.
 * Assumes cmx_pkg and cmx_src_model are compiled first.
 */
`timescale 1ns/1ps

module tb_cmx_mixer
    import cmx_pkg::*;
;
    typedef int cmx_seq_t [4];
    localparam int TOL = 6;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] rate_mode = 2'b10;
    logic sync_strobe = 1'b0;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [10:0] gain_i = 11'h400;
    logic [10:0] gain_q = 11'h400;
    logic [9:0] skew = 10'h000;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic signed [15:0] a_val = 16'h1770;
    logic signed [15:0] b_val = 16'hF830;
    logic sample_en;
    logic signed [15:0] a_in, b_in, a_out, b_out;
    logic out_valid;
    int bad_count = 0;
    int checked = 0;
    int ca [10];
    int cb [10];

    // Free-running 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    cmx_src_model src_u (.clk(clk_sys), .run(run), .slow(slow), .a_val(a_val),
        .b_val(b_val), .sample_en(sample_en), .a_out(a_in), .b_out(b_in));

    cmx_mixer dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .SAMPLE_EN(sample_en),
        .RATE_MODE(rate_mode), .PHASE_SYNC_STROBE(sync_strobe), .CFG_WE(cfg_we),
        .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .QMC_GAIN_I(gain_i),
        .QMC_GAIN_Q(gain_q), .QMC_SKEW(skew), .A_IN(a_in), .B_IN(b_in),
        .A_OUT(a_out), .B_OUT(b_out), .OUT_VALID(out_valid));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        bad_count++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask : fail

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Ideal mixer output at zero angle; sin/cos ripple is inside TOL
    function automatic int fine(input int v, input bit g);
        return g ? (v * 32767) >>> 15 : (v * 32767) >>> 16;
    endfunction : fine

    task automatic cfg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        cfg_we = 1'b1;
        cfg_addr = addr;
        cfg_wdata = data;
        @(negedge clk_sys);
        cfg_we = 1'b0;
    endtask : cfg_wr

    task automatic set_nco(input logic [31:0] freq, input logic [15:0] phase);
        cfg_wr(CMX_ADDR_FREQ0, freq[7:0]);
        cfg_wr(CMX_ADDR_FREQ1, freq[15:8]);
        cfg_wr(CMX_ADDR_FREQ2, freq[23:16]);
        cfg_wr(CMX_ADDR_FREQ3, freq[31:24]);
        cfg_wr(CMX_ADDR_PHASE_HI, phase[15:8]);
        cfg_wr(CMX_ADDR_PHASE_LO, phase[7:0]);
    endtask : set_nco

    // Ten valid samples; the wait is bounded so a stalled stream fails
    task automatic capture(input int flush);
        int n;
        int guard;
        n = 0;
        guard = 0;
        repeat (flush) @(negedge clk_sys);
        while (n < 10 && guard < 100) begin
            @(negedge clk_sys);
            guard++;
            if (out_valid === 1'b1) begin
                if ((^{a_out, b_out}) === 1'bx) fail("unknown output");
                ca[n] = int'(a_out);
                cb[n] = int'(b_out);
                n++;
            end
        end
        if (n < 10) fail("output samples missing");
    endtask : capture

    // Start phase of a periodic sequence is free up to khi; d repeats each entry
    task automatic check_seq(input string what, input cmx_seq_t ea, input cmx_seq_t eb,
        input int d, input int s, input int khi);
        bit hit;
        bit ok;
        int j;
        hit = 0;
        for (int k = 0; k <= khi; k++) begin
            ok = 1;
            for (int i = 0; i < 8; i++) begin
                j = ((i + k) / d) % 4;
                if (ca[s+i] - ea[j] > TOL || ea[j] - ca[s+i] > TOL) ok = 0;
                if (cb[s+i] - eb[j] > TOL || eb[j] - cb[s+i] > TOL) ok = 0;
            end
            if (ok) hit = 1;
        end
        checked++;
        if (!hit) fail(what);
    endtask : check_seq

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        checked++;
        if (a_out !== 16'h0000 || b_out !== 16'h0000 || out_valid !== 1'b0) begin
            fail("outputs not cleared in reset");
        end
        $display("done reset");
    endtask : t_reset

    task automatic t_fine();
        int x, y;
        x = fine(6000, 1'b0);
        y = fine(-2000, 1'b0);
        run = 1'b1;
        capture(12);
        check_seq("zero config", '{x, x, x, x}, '{y, y, y, y}, 1, 2, 0);
        set_nco(32'h0000_0000, 16'h4000);
        capture(12);
        check_seq("quarter offset", '{-y, -y, -y, -y}, '{x, x, x, x}, 1, 2, 0);
        set_nco(32'h0000_0000, 16'h8000);
        capture(12);
        check_seq("half offset", '{-x, -x, -x, -x}, '{-y, -y, -y, -y}, 1, 2, 0);
        // Unmapped address must leave the words alone
        cfg_wr(8'h05, 8'hFF);
        capture(12);
        check_seq("unmapped write", '{-x, -x, -x, -x}, '{-y, -y, -y, -y}, 1, 2, 0);
        set_nco(32'h0000_0000, 16'h0000);
        cfg_wr(CMX_ADDR_CFG2, 8'h40);
        x = fine(6000, 1'b1);
        y = fine(-2000, 1'b1);
        capture(12);
        check_seq("high gain", '{x, x, x, x}, '{y, y, y, y}, 1, 2, 0);
        cfg_wr(CMX_ADDR_CFG2, 8'h00);
        $display("done fine");
    endtask : t_fine

    task automatic t_rotation();
        int x, y;
        x = fine(6000, 1'b0);
        y = fine(-2000, 1'b0);
        set_nco(32'h4000_0000, 16'h0000);
        capture(12);
        check_seq("plus quarter", '{x, -y, -x, y}, '{y, x, -y, -x}, 1, 2, 3);
        set_nco(32'hC000_0000, 16'h0000);
        capture(12);
        check_seq("minus quarter", '{x, y, -x, -y}, '{y, -x, -y, x}, 1, 2, 3);
        slow = 1'b1;
        capture(12);
        check_seq("gapped stream", '{x, y, -x, -y}, '{y, -x, -y, x}, 1, 2, 3);
        slow = 1'b0;
        // Every half-rate mode steps the oscillator on alternate samples
        for (int m = 0; m < 4; m++) begin
            if (m == 2) continue;
            rate_mode = 2'(m);
            capture(12);
            check_seq("half rate", '{x, y, -x, -y}, '{y, -x, -y, x}, 2, 2, 7);
        end
        rate_mode = 2'b10;
        $display("done rotation");
    endtask : t_rotation

    task automatic t_sync();
        int x, y;
        x = fine(6000, 1'b0);
        y = fine(-2000, 1'b0);
        run = 1'b0;
        set_nco(32'h4000_0000, 16'h0000);
        sync_strobe = 1'b1;
        repeat (3) @(negedge clk_sys);
        sync_strobe = 1'b0;
        repeat (6) @(negedge clk_sys);
        run = 1'b1;
        // First fresh output is sample 0 at zero accumulator phase
        capture(0);
        check_seq("sync origin", '{x, -y, -x, y}, '{y, x, -y, -x}, 1, 2, 0);
        set_nco(32'h0000_0000, 16'h0000);
        // Park the accumulator at zero phase for the coarse mixer tests
        sync_strobe = 1'b1;
        repeat (3) @(negedge clk_sys);
        sync_strobe = 1'b0;
        $display("done sync");
    endtask : t_sync

    task automatic t_coarse();
        int x, y, p, q;
        cmx_seq_t ea, eb;
        gain_i = 11'h5A6;
        gain_q = 11'h200;
        skew = 10'h300;
        x = (fine(6000, 1'b0) * 1446) >>> 10;
        y = (fine(-2000, 1'b0) * 512 - fine(6000, 1'b0) * 256) >>> 10;
        for (int c = 0; c < 16; c++) begin
            cfg_wr(CMX_ADDR_CFG2, 8'(c));
            p = c[1] ? -1 : 1;
            q = c[0] ? -1 : 1;
            case (c[3:2])
                2'b00: begin
                    ea = '{x, x, x, x};
                    eb = '{y, y, y, y};
                end
                2'b01: begin
                    ea = '{-p * x, p * x, -p * x, p * x};
                    eb = '{-q * y, q * y, -q * y, q * y};
                end
                2'b10: begin
                    ea = '{p * x, -p * y, -p * x, p * y};
                    eb = '{q * y, q * x, -q * y, -q * x};
                end
                default: begin
                    ea = '{p * x, p * y, -p * x, -p * y};
                    eb = '{-q * -y, -q * x, -q * y, q * x};
                end
            endcase
            capture(12);
            check_seq("coarse code", ea, eb, 1, 2, 3);
        end
        $display("done coarse");
    endtask : t_coarse

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk_sys);
        t_reset();
        resetn = 1'b1;
        t_fine();
        t_rotation();
        t_sync();
        t_coarse();
        tally_and_finish();
    end

    // Whole run needs about 6 us; ten times that means a hang
    initial begin
        #60000;
        fail("watchdog expired");
        tally_and_finish();
    end
endmodule : tb_cmx_mixer
